// file: core/seap_top.sv
/*
  Serial EEPROM access port: one command register, a serial engine and the
  load of identity and latency/grant values after reset.
  Assumes a register port on the bus clock and a three-wire EEPROM whose
  data line is pulled high when nobody drives it.
*/
`timescale 1ns/1ps
module seap_top #(
  parameter int WR_TMO_CYC = seap_pkg::SEAP_WR_TMO_CYC
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic eeprom_chip_select_out,
  output logic eeprom_serial_clock_out,
  output logic eeprom_serial_data_out,
  output logic eeprom_serial_data_oe_out,
  input wire logic eeprom_serial_data_in,
  output logic [31:0] subsystem_identification_out,
  output logic [7:0] max_latency_out,
  output logic [1:0] min_grant_out
);
  seap_pkg::seap_eng_s e_q;
  seap_pkg::seap_eng_s e_d;
  seap_pkg::seap_regs_s r_q;
  seap_pkg::seap_regs_s r_d;
  logic [31:0] tmo_q;
  logic [31:0] tmo_d;
  logic din_s;
  logic tick;

  // Register port decode
  wire addr_hit = (reg_addr_in == seap_pkg::SEAP_REG_OFFSET);
  wire wr_hit = reg_sel_in && reg_wr_in && addr_hit;
  wire wr_ok = wr_hit && !r_q.busy;
  wire rd_hit = reg_sel_in && !reg_wr_in;
  wire seap_pkg::seap_cmd_s wcmd = reg_wdata_in[23:0];
  wire [31:0] reg_view = {seap_pkg::SEAP_RSVD_RST, r_q.present, r_q.busy, r_q.cmd};

  // Engine decode
  wire is_read = (e_q.cur.op == seap_pkg::SEAP_OP_READ);
  wire last_clk = (e_q.cnt == e_q.len - 5'h01);
  wire cs_gap_end = (tmo_q == 32'(seap_pkg::SEAP_CS_LOW_CYC - 1));
  wire poll_tmo = (tmo_q == 32'(WR_TMO_CYC - 1));
  wire seap_pkg::seap_cmd_s auto_cmd = '{op: seap_pkg::SEAP_OP_READ,
                                         addr: {4'h0, e_q.idx}, data: 16'h0000};
  wire seap_pkg::seap_cmd_s launch_cmd = e_q.auto_ld ? auto_cmd : r_q.cmd;
  wire launch = (e_q.st == seap_pkg::SEAP_IDLE) && (e_q.auto_ld || r_q.busy);

  seap_sync #(
    .WIDTH(1)
  ) u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .async_in(eeprom_serial_data_in),
    .sync_out(din_s)
  );

  seap_tick #(
    .HALF(seap_pkg::SEAP_SK_HALF_CYC)
  ) u_tick (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .en_in(e_q.st == seap_pkg::SEAP_SHIFT),
    .tick_out(tick)
  );

  // Next state of the register file and the serial engine
  always_comb begin
    e_d = e_q;
    r_d = r_q;
    tmo_d = tmo_q;
    if (rd_hit) begin
      r_d.rdata = addr_hit ? reg_view : 32'h0000_0000;
    end
    if (wr_ok) begin
      r_d.cmd = wcmd;
      r_d.busy = reg_wdata_in[seap_pkg::SEAP_BUSY_BIT];
    end
    case (e_q.st)
      seap_pkg::SEAP_IDLE: begin
        if (launch) begin
          r_d.busy = 1'b1;
          e_d.cur = launch_cmd;
          e_d.sr = {1'b1, launch_cmd};
          e_d.len = seap_pkg::seap_len(launch_cmd);
          e_d.cnt = 5'h00;
          e_d.sk = 1'b0;
          e_d.cs = 1'b1;
          e_d.oe = 1'b1;
          e_d.dout = 1'b1;
          e_d.rx = 17'h1FFFF;
          e_d.st = seap_pkg::SEAP_SHIFT;
        end
      end
      seap_pkg::SEAP_SHIFT: begin
        if (tick && !e_q.sk) begin
          // Rising edge: sample read data before raising the clock
          e_d.sk = 1'b1;
          if (is_read && e_q.cnt >= seap_pkg::SEAP_CMD_BITS) begin
            e_d.rx = {e_q.rx[15:0], din_s};
          end
        end else if (tick) begin
          // Falling edge: present the next bit
          e_d.sk = 1'b0;
          e_d.cnt = e_q.cnt + 5'h01;
          e_d.sr = {e_q.sr[23:0], 1'b0};
          e_d.dout = e_q.sr[23];
          if (is_read && e_q.cnt == seap_pkg::SEAP_CMD_BITS - 5'h01) begin
            e_d.oe = 1'b0; // Release the line for the read data
            e_d.dout = 1'b0;
          end
          if (last_clk) begin
            e_d.cs = 1'b0;
            e_d.oe = 1'b0;
            e_d.dout = 1'b0;
            tmo_d = 32'h0000_0000;
            e_d.st = seap_pkg::SEAP_GAP;
          end
        end
      end
      seap_pkg::SEAP_GAP: begin
        tmo_d = tmo_q + 32'h0000_0001;
        if (cs_gap_end) begin
          tmo_d = 32'h0000_0000;
          if (seap_pkg::seap_needs_poll(e_q.cur)) begin
            e_d.cs = 1'b1; // Reselect to watch the ready line
            e_d.seen_low = 1'b0;
            e_d.st = seap_pkg::SEAP_POLL;
          end else begin
            e_d.ok = is_read ? !e_q.rx[16] : r_q.present;
            e_d.st = seap_pkg::SEAP_DONE;
          end
        end
      end
      seap_pkg::SEAP_POLL: begin
        tmo_d = tmo_q + 32'h0000_0001;
        if (!din_s) begin
          e_d.seen_low = 1'b1;
        end
        if (e_q.seen_low && din_s) begin
          e_d.ok = 1'b1;
          e_d.cs = 1'b0;
          e_d.st = seap_pkg::SEAP_DONE;
        end else if (poll_tmo) begin
          e_d.ok = 1'b0;
          e_d.cs = 1'b0;
          e_d.st = seap_pkg::SEAP_DONE;
        end
      end
      seap_pkg::SEAP_DONE: begin
        r_d.present = e_q.ok;
        e_d.st = seap_pkg::SEAP_IDLE;
        if (!e_q.auto_ld) begin
          if (is_read && e_q.ok) begin
            r_d.cmd.data = e_q.rx[15:0];
          end
          r_d.busy = 1'b0;
        end else if (!e_q.ok) begin
          e_d.auto_ld = 1'b0;
          r_d.busy = 1'b0;
        end else begin
          case (e_q.idx)
            seap_pkg::SEAP_WORD_IDENT_LO: r_d.ident[15:0] = e_q.rx[15:0];
            seap_pkg::SEAP_WORD_IDENT_HI: r_d.ident[31:16] = e_q.rx[15:0];
            default: begin
              r_d.lat = e_q.rx[15:8];
              r_d.gnt = e_q.rx[1:0];
            end
          endcase
          e_d.idx = e_q.idx + 2'h1;
          if (e_q.idx == seap_pkg::SEAP_WORD_LAT_GNT) begin
            e_d.auto_ld = 1'b0;
            r_d.busy = 1'b0;
          end
        end
      end
      default: begin
        e_d = seap_pkg::SEAP_ENG_RST;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      e_q <= seap_pkg::SEAP_ENG_RST;
      r_q <= seap_pkg::SEAP_REGS_RST;
      tmo_q <= 32'h0000_0000;
    end else begin
      e_q <= e_d;
      r_q <= r_d;
      tmo_q <= tmo_d;
    end
  end

  // Outputs come straight from the state registers
  assign reg_rdata_out = r_q.rdata;
  assign eeprom_chip_select_out = e_q.cs;
  assign eeprom_serial_clock_out = e_q.sk;
  assign eeprom_serial_data_out = e_q.dout;
  assign eeprom_serial_data_oe_out = e_q.oe;
  assign subsystem_identification_out = r_q.ident;
  assign max_latency_out = r_q.lat;
  assign min_grant_out = r_q.gnt;

  // Checks on the register and engine behaviour
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_user_done;
    e_q.st == seap_pkg::SEAP_DONE && !e_q.auto_ld;
  endsequence

  sequence s_start_write;
    wr_ok && reg_wdata_in[seap_pkg::SEAP_BUSY_BIT];
  endsequence

  property p_launch;
    s_start_write |=> r_q.busy ##1 (e_q.st == seap_pkg::SEAP_SHIFT && e_q.cs && e_q.oe
                                    && e_q.dout);
  endproperty

  chk_start_launch: assert property (p_launch)
    else $error("start write did not launch a frame");

  chk_busy_write_ignore: assert property (
    (wr_hit && r_q.busy) |=> $stable(r_q.cmd.op) && $stable(r_q.cmd.addr)
      && ($stable(r_q.cmd.data) || $past(e_q.st) == seap_pkg::SEAP_DONE))
    else $error("write accepted while busy");

  chk_busy_clear_done: assert property (
    s_user_done |=> !r_q.busy && e_q.st == seap_pkg::SEAP_IDLE)
    else $error("busy not cleared at completion");

  chk_absent_data_kept: assert property (
    (s_user_done and (!e_q.ok)) |=> !r_q.present && $stable(r_q.cmd.data))
    else $error("failed command changed data or set presence");

  chk_read_data_load: assert property (
    (s_user_done and (is_read && e_q.ok)) |=> r_q.cmd.data == $past(e_q.rx[15:0])
                                             && r_q.present)
    else $error("read word not placed in data field");

  chk_reserved_read_zero: assert property (
    rd_hit |=> reg_rdata_out[31:26] == 6'h00
               && reg_rdata_out[24] == ($past(r_q.busy) && $past(addr_hit)))
    else $error("reserved bits or busy wrong on read");

  chk_autoload_busy: assert property (
    (e_q.auto_ld && e_q.st != seap_pkg::SEAP_IDLE) |-> r_q.busy)
    else $error("busy low during load after reset");

  chk_read_frame_len: assert property (
    (launch && launch_cmd.op == seap_pkg::SEAP_OP_READ) |=> e_q.len == 5'h1A
                                                           && e_q.sr[24])
    else $error("read frame length wrong");

  chk_chip_select_frame: assert property (
    (e_q.st == seap_pkg::SEAP_SHIFT) |-> e_q.cs)
    else $error("chip select low while shifting");

  chk_ident_absent_zero: assert property (
    (e_q.st == seap_pkg::SEAP_DONE && e_q.auto_ld && !e_q.ok
     && e_q.idx == seap_pkg::SEAP_WORD_IDENT_LO) |=> subsystem_identification_out == 32'h0)
    else $error("identity not zero without EEPROM");

  // Link discipline between and inside frames, presence on writes, poll timeout, and the low identity and latency/grant loads after reset
  sequence s_auto_done;
    e_q.st == seap_pkg::SEAP_DONE && e_q.auto_ld && e_q.ok;
  endsequence

  chk_idle_link_quiet: assert property (
    (e_q.st == seap_pkg::SEAP_IDLE) |-> !e_q.cs && !e_q.sk && !e_q.oe)
    else $error("link not quiet while idle");

  chk_gap_select_low: assert property (
    (e_q.st == seap_pkg::SEAP_GAP) |-> !e_q.cs && !e_q.oe)
    else $error("select or drive high in the gap");

  chk_read_line_free: assert property (
    (e_q.st == seap_pkg::SEAP_SHIFT && is_read && e_q.cnt >= seap_pkg::SEAP_CMD_BITS)
    |-> !e_q.oe)
    else $error("line driven during read data");

  chk_write_keeps_present: assert property (
    wr_ok |=> r_q.present == $past(r_q.present))
    else $error("register write changed presence");

  chk_poll_timeout_fail: assert property (
    (e_q.st == seap_pkg::SEAP_POLL && poll_tmo && !(e_q.seen_low && din_s))
    |=> e_q.st == seap_pkg::SEAP_DONE && !e_q.ok)
    else $error("poll timeout did not fail the command");

  chk_ident_low_load: assert property (
    (s_auto_done and (e_q.idx == seap_pkg::SEAP_WORD_IDENT_LO))
    |=> subsystem_identification_out[15:0] == $past(e_q.rx[15:0]))
    else $error("identity low half not loaded");

  chk_grant_load: assert property (
    (s_auto_done and (e_q.idx == seap_pkg::SEAP_WORD_LAT_GNT))
    |=> max_latency_out == $past(e_q.rx[15:8]) && min_grant_out == $past(e_q.rx[1:0]))
    else $error("latency or grant not loaded");

endmodule : seap_top

// file: inc/seap_pkg.sv
/*
  Constants, types and helper functions for the serial EEPROM access port.
  Assumes a single bus clock domain of 40 MHz and a three-wire serial EEPROM.
*/
// Overview of operation
// - One word write carries start, command, address, data.
// - Presence clear means failed command, garbage data.
// - Completed read returns word in bits 15-0.
// - Presence flag read-only, valid when not busy.
// - Writing start one launches the transaction.
// - While busy, flag reads one, writes ignored.
// - Busy flag clears when transaction ends.
// - Opcode 10 read, 01 write, 11 erase.
// - Opcode 00 sub-command from address bits 5-4.
// - Bits 21-16 give the serial word address.
// - Reserved and presence read zero after reset; busy reads one while the load runs.
// - Identity words loaded after reset, else zero.
// - Latency byte and two grant bits loaded too.
package seap_pkg;

  localparam logic [15:0] SEAP_REG_OFFSET = 16'hF100;
  localparam int SEAP_PRESENT_BIT = 25;
  localparam int SEAP_BUSY_BIT = 24;
  localparam int SEAP_OP_LSB = 22;
  localparam int SEAP_ADDR_LSB = 16;
  localparam logic [5:0] SEAP_RSVD_RST = 6'h00;

  localparam logic [1:0] SEAP_OP_EXT = 2'h0;
  localparam logic [1:0] SEAP_OP_WRITE = 2'h1;
  localparam logic [1:0] SEAP_OP_READ = 2'h2;
  localparam logic [1:0] SEAP_OP_ERASE = 2'h3;
  localparam logic [1:0] SEAP_SUB_EWDS = 2'h0;
  localparam logic [1:0] SEAP_SUB_WRAL = 2'h1;
  localparam logic [1:0] SEAP_SUB_ERAL = 2'h2;
  localparam logic [1:0] SEAP_SUB_EWEN = 2'h3;

  localparam logic [4:0] SEAP_CMD_BITS = 5'h09;
  localparam logic [4:0] SEAP_LEN_SHORT = 5'h09;
  localparam logic [4:0] SEAP_LEN_WRITE = 5'h19;
  localparam logic [4:0] SEAP_LEN_READ = 5'h1A;

  localparam logic [1:0] SEAP_WORD_IDENT_LO = 2'h1;
  localparam logic [1:0] SEAP_WORD_IDENT_HI = 2'h2;
  localparam logic [1:0] SEAP_WORD_LAT_GNT = 2'h3;

  localparam int SEAP_CLK_NS = 25;
  localparam int SEAP_SK_HALF_NS = 500;
  localparam int SEAP_CS_LOW_NS = 250;
  localparam int SEAP_WR_TMO_NS = 10000000;
  localparam int SEAP_SK_HALF_CYC = (SEAP_SK_HALF_NS + SEAP_CLK_NS - 1) / SEAP_CLK_NS;
  localparam int SEAP_CS_LOW_CYC = (SEAP_CS_LOW_NS + SEAP_CLK_NS - 1) / SEAP_CLK_NS;
  localparam int SEAP_WR_TMO_CYC = SEAP_WR_TMO_NS / SEAP_CLK_NS;

  typedef enum logic [2:0] {
    SEAP_IDLE = 3'h0,
    SEAP_SHIFT = 3'h1,
    SEAP_GAP = 3'h2,
    SEAP_POLL = 3'h3,
    SEAP_DONE = 3'h4
  } seap_state_e;

  typedef struct packed {
    logic [1:0] op;
    logic [5:0] addr;
    logic [15:0] data;
  } seap_cmd_s;

  typedef struct packed {
    seap_state_e st;
    logic auto_ld;
    logic [1:0] idx;
    seap_cmd_s cur;
    logic [24:0] sr;
    logic [16:0] rx;
    logic [4:0] cnt;
    logic [4:0] len;
    logic sk;
    logic cs;
    logic dout;
    logic oe;
    logic seen_low;
    logic ok;
  } seap_eng_s;

  typedef struct packed {
    logic busy;
    logic present;
    seap_cmd_s cmd;
    logic [31:0] ident;
    logic [7:0] lat;
    logic [1:0] gnt;
    logic [31:0] rdata;
  } seap_regs_s;

  localparam seap_eng_s SEAP_ENG_RST = '{st: SEAP_IDLE, auto_ld: 1'b1, idx: SEAP_WORD_IDENT_LO,
                                         default: '0};
  localparam seap_regs_s SEAP_REGS_RST = '{default: '0};

  // Number of serial clocks a command takes
  function automatic logic [4:0] seap_len(input seap_cmd_s c);
    logic [4:0] n;
    n = SEAP_LEN_SHORT;
    if (c.op == SEAP_OP_READ) begin
      n = SEAP_LEN_READ;
    end else if (c.op == SEAP_OP_WRITE) begin
      n = SEAP_LEN_WRITE;
    end else if (c.op == SEAP_OP_EXT && c.addr[5:4] == SEAP_SUB_WRAL) begin
      n = SEAP_LEN_WRITE;
    end
    return n;
  endfunction : seap_len

  // Commands that program the array and must wait for ready
  function automatic logic seap_needs_poll(input seap_cmd_s c);
    logic p;
    p = (c.op == SEAP_OP_WRITE) || (c.op == SEAP_OP_ERASE);
    if (c.op == SEAP_OP_EXT) begin
      p = (c.addr[5:4] == SEAP_SUB_WRAL) || (c.addr[5:4] == SEAP_SUB_ERAL);
    end
    return p;
  endfunction : seap_needs_poll

endpackage : seap_pkg

// file: core/seap_sync.sv
/*
  Two-flop synchroniser for levels arriving from pins.
  Assumes the destination is the bus clock domain.
*/
`timescale 1ns/1ps
module seap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : seap_sync

// file: core/seap_tick.sv
/*
  Half-period tick generator for the EEPROM serial clock.
  Assumes the enable stays high for the whole shift phase.
*/
`timescale 1ns/1ps
module seap_tick #(
  parameter int HALF = 20
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  output logic tick_out
);
  logic [15:0] cnt_q;
  logic tick_q;
  logic wrap;

  assign wrap = (cnt_q == 16'(HALF - 1));

  // Restart whenever disabled so every frame begins with a full half period
  always_ff @(posedge mclk_in) begin
    if (!rstn_in || !en_in) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      tick_q <= wrap;
    end
  end

  assign tick_out = tick_q;
endmodule : seap_tick

// file: sim/seap_eeprom_model.sv
/*
  Behavioural three-wire serial EEPROM of 64 sixteen-bit words.
  Assumes the device drives select and clock and the bench resolves the
  data wire with a pull-up.
*/
`timescale 1ns/1ps
module seap_eeprom_model (
  input wire logic cs_in,
  input wire logic sk_in,
  input wire logic di_in,
  input wire logic present_in,
  input wire logic [7:0] busy_cyc_in,
  output logic do_out,
  output logic oe_out
);
  logic [15:0] mem [64];
  logic [24:0] sh = '0;
  logic [15:0] rd_w = '0;
  logic [7:0] c = '0;
  int n = 0;
  logic ewen = 1'b0;
  logic rd = 1'b0;
  logic pend = 1'b0;
  logic pg;

  // Identity and latency/grant words, user area cleared
  initial begin
    do_out = 1'b0;
    oe_out = 1'b0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'h0000;
    end
    mem[1] = 16'h1234;
    mem[2] = 16'hABCD;
    mem[3] = 16'h5A02;
  end

  // Shift in start bit, opcode, address and data on rising clock
  always @(posedge sk_in) begin
    if (cs_in && present_in) begin
      if (!rd) begin
        oe_out = 1'b0;
      end
      sh = {sh[23:0], di_in};
      n = n + 1;
      if (n == 9 && sh[7:6] == 2'h2) begin
        rd = 1'b1;
        rd_w = mem[sh[5:0]];
      end
    end
  end

  // Read output: dummy zero, then the word MSB first on falling clock
  always @(negedge sk_in) begin
    if (rd && cs_in) begin
      oe_out = 1'b1;
      do_out = (n == 9) ? 1'b0 : rd_w[15];
      if (n > 9) begin
        rd_w = {rd_w[14:0], 1'b0};
      end
    end
  end

  // Frame end: execute the command; programming only when enabled
  always @(negedge cs_in) begin
    oe_out = 1'b0;
    rd = 1'b0;
    c = (n == 25) ? sh[23:16] : sh[7:0];
    if (n == 9 && c[7:4] == 4'h3) begin
      ewen = 1'b1;
    end
    if (n == 9 && c[7:4] == 4'h0) begin
      ewen = 1'b0;
    end
    pg = ewen && ((n == 25 && (c[7:6] == 2'h1 || c[7:4] == 4'h1)) ||
                  (n == 9 && (c[7:6] == 2'h3 || c[7:4] == 4'h2)));
    for (int i = 0; i < 64; i++) begin
      if (pg && (c[7:6] == 2'h0 || i == c[5:0])) begin
        mem[i] = (n == 25) ? sh[15:0] : 16'hFFFF;
      end
    end
    pend = pg;
    n = 0;
  end

  // Ready status while selected: low while programming, then high
  always @(posedge cs_in) begin
    if (pend && present_in) begin
      oe_out = 1'b1;
      do_out = 1'b0;
      #(busy_cyc_in * 25);
      do_out = 1'b1;
      pend = 1'b0;
    end
  end
endmodule : seap_eeprom_model

// file: sim/testbench.sv
/*
  Self-checking bench for the serial EEPROM access port.
  Assumes the EEPROM model beside it and a pulled-up data wire.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic present = 1'b1;
  logic [7:0] busy_cyc = 8'h14;
  logic [31:0] rdata, ident, v;
  logic [7:0] lat;
  logic [1:0] gnt;
  logic cs, sk, d_out, d_oe, sdat, m_do, m_oe;
  int failures = 0;
  int total_checks = 0;

  // Data wire: device, then model, else pull-up
  assign sdat = d_oe ? d_out : (m_oe ? m_do : 1'b1);

  seap_top #(.WR_TMO_CYC(200)) dut (.mclk_in(mclk), .rstn_in(rstn), .reg_sel_in(sel),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .eeprom_chip_select_out(cs), .eeprom_serial_clock_out(sk),
    .eeprom_serial_data_out(d_out), .eeprom_serial_data_oe_out(d_oe),
    .eeprom_serial_data_in(sdat), .subsystem_identification_out(ident),
    .max_latency_out(lat), .min_grant_out(gnt));

  seap_eeprom_model mem_model (.cs_in(cs), .sk_in(sk), .di_in(sdat), .present_in(present),
    .busy_cyc_in(busy_cyc), .do_out(m_do), .oe_out(m_oe));

  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    sel <= 1'b1;
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    sel <= 1'b0;
    wr <= 1'b0;
  endtask : reg_wr

  // Read data is registered one cycle after the strobe edge
  task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge mclk);
    sel <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge mclk);
    sel <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic poll;
    for (int i = 0; i < 4000; i++) begin
      reg_rd(16'hF100, v);
      if (v[24] === 1'b0) begin
        break;
      end
    end
  endtask : poll

  // Launch, try a write while busy, wait, compare the whole register
  task automatic run(input logic [1:0] op, input logic [5:0] ad, input logic [15:0] d,
                     input logic pres, input logic [15:0] ed);
    reg_wr(16'hF100, {8'h01, op, ad, d});
    reg_rd(16'hF100, v);
    check(v[24], 1'b1);
    reg_wr(16'hF100, 32'hFFFF_FFFF);
    poll;
    check(v, {6'h00, pres, 1'b0, op, ad, ed});
    check(cs, 1'b0);
  endtask : run

  task automatic do_reset;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask : do_reset

  // Main sequence
  initial begin
    do_reset;
    reg_rd(16'hF100, v);
    check(v[31:24], 8'h01);
    poll;
    check(v[25], 1'b1);
    check(ident, 32'hABCD_1234);
    check({lat, gnt}, {8'h5A, 2'h2});
    run(2'h1, 6'h09, 16'hA55A, 1'b0, 16'hA55A);
    run(2'h2, 6'h09, 16'h0000, 1'b1, 16'h0000);
    run(2'h0, 6'h30, 16'h0000, 1'b1, 16'h0000);
    run(2'h1, 6'h09, 16'hA55A, 1'b1, 16'hA55A);
    run(2'h2, 6'h09, 16'h0000, 1'b1, 16'hA55A);
    run(2'h3, 6'h09, 16'h0000, 1'b1, 16'h0000);
    run(2'h2, 6'h09, 16'h0000, 1'b1, 16'hFFFF);
    busy_cyc <= 8'h96;
    run(2'h0, 6'h10, 16'h1357, 1'b1, 16'h1357);
    run(2'h2, 6'h3F, 16'h0000, 1'b1, 16'h1357);
    run(2'h0, 6'h20, 16'h0000, 1'b1, 16'h0000);
    run(2'h2, 6'h00, 16'h0000, 1'b1, 16'hFFFF);
    run(2'h0, 6'h00, 16'h0000, 1'b1, 16'h0000);
    run(2'h1, 6'h08, 16'h0F0F, 1'b0, 16'h0F0F);
    reg_wr(16'hF104, 32'h0180_0000);
    reg_rd(16'hF100, v);
    check(v[24], 1'b0);
    reg_rd(16'hF104, v);
    check(v, 32'h0000_0000);
    present <= 1'b0;
    run(2'h2, 6'h01, 16'h0000, 1'b0, 16'h0000);
    do_reset;
    poll;
    check(v[25:24], 2'h0);
    check(ident, 32'h0000_0000);
    check({lat, gnt}, 10'h000);
    end_sim;
  end

  // Watchdog against a hung handshake
  initial begin
    #2_000_000;
    failures++;
    end_sim;
  end
endmodule : testbench
